// >>> tsq_top.sv
// transceiver tx and rx reset sequencer with wishbone control
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module tsq_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // tx reset pins, asynchronous
  input  wire logic        full_tx_reset_i,
  input  wire logic        tx_analog_layer_reset_i,
  input  wire logic        tx_coding_layer_reset_i,
  input  wire logic        tx_user_clocks_stable_i,
  // rx reset pins, asynchronous
  input  wire logic        full_rx_reset_i,
  input  wire logic        rx_analog_layer_reset_i,
  input  wire logic        rx_equalizer_reset_i,
  input  wire logic        rx_margin_scan_reset_i,
  input  wire logic        rx_coding_layer_reset_i,
  input  wire logic        rx_elastic_buffer_reset_i,
  input  wire logic        rx_user_clocks_stable_i,
  input  wire logic        reset_mode_select_i,
  // block resets toward the channel
  output logic             tx_analog_rst_o,
  output logic             tx_coding_rst_o,
  output logic             tx_buffer_rst_o,
  output logic      [6:0]  rx_stage_rst_o,
  // status toward the user
  output logic      [2:0]  tx_rate_o,
  output logic             tx_rate_change_complete_o,
  output logic             tx_reset_complete_o,
  output logic             rx_reset_complete_o
);
  tsq_sync_if #(.W(tsq_pkg::SI_W)) sif ();

  tsq_sync #(.W(tsq_pkg::SI_W)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (sif.sync)
  );

  assign sif.raw = {reset_mode_select_i, rx_user_clocks_stable_i, rx_elastic_buffer_reset_i,
                    rx_coding_layer_reset_i, rx_margin_scan_reset_i, rx_equalizer_reset_i,
                    rx_analog_layer_reset_i, full_rx_reset_i, tx_user_clocks_stable_i,
                    tx_coding_layer_reset_i, tx_analog_layer_reset_i, full_tx_reset_i};

  function automatic logic [6:0] stage_bit(input logic [2:0] idx);
    stage_bit = 7'(8'h01 << idx);
  endfunction

  logic [tsq_pkg::SI_W-1:0] lvl_q;
  logic [tsq_pkg::SI_W-1:0] rel;
  logic [5:0]               ctrl;
  tsq_pkg::tsq_tx_e         tx_state;
  tsq_pkg::tsq_rx_e         rx_state;
  logic [7:0]               tx_cnt;
  logic [7:0]               rx_cnt;
  logic                     rate_run;
  logic [2:0]               rx_idx;
  logic [2:0]               rx_last;
  logic                     ftx;
  logic                     frx;
  logic                     tus;
  logic                     rus;
  logic                     seq_mode;
  logic                     any_rx_req;

  assign ftx        = sif.lvl[tsq_pkg::SI_FTX];
  assign frx        = sif.lvl[tsq_pkg::SI_FRX];
  assign tus        = sif.lvl[tsq_pkg::SI_TUS];
  assign rus        = sif.lvl[tsq_pkg::SI_RUS];
  assign seq_mode   = ~sif.lvl[tsq_pkg::SI_MODE];
  assign any_rx_req = |sif.lvl[tsq_pkg::SI_REB:tsq_pkg::SI_RAN];
  // a release is a falling synchronised level
  assign rel        = lvl_q & ~sif.lvl; // RULE_22

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lvl_q <= '0;
    else
      lvl_q <= sif.lvl;
  end

  // wishbone slave: one wait state, ack for every address, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl     <= tsq_pkg::CTRL_RESET;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        if (wb_adr_i == tsq_pkg::REG_CTRL)
        begin
          if (wb_we_i && wb_sel_i[0])
            ctrl <= wb_dat_i[5:0];
          wb_dat_o <= {26'h0, ctrl};
        end
        else if (wb_adr_i == tsq_pkg::REG_STATUS)
        begin
          wb_dat_o <= {19'h0, tx_rate_o, 1'b0, rx_idx, seq_mode, (tx_state != tsq_pkg::TX_IDLE),
                       rate_run, (rx_state != tsq_pkg::RX_IDLE), rx_reset_complete_o,
                       tx_reset_complete_o};
        end
      end
    end
  end

  // tx sequencer; the full reset also restarts the sequencer itself
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_state                  <= tsq_pkg::TX_IDLE;
      tx_cnt                    <= 8'h0;
      tx_analog_rst_o           <= 1'b0;
      tx_coding_rst_o           <= 1'b0;
      tx_buffer_rst_o           <= 1'b0;
      tx_reset_complete_o       <= 1'b0;
      tx_rate_change_complete_o <= 1'b0;
      tx_rate_o                 <= 3'h0;
      rate_run                  <= 1'b0;
    end
    else
    begin
      tx_rate_change_complete_o <= 1'b0;
      if (ftx)
      begin
        tx_state            <= tsq_pkg::TX_HOLD; // RULE_01
        tx_analog_rst_o     <= 1'b1;
        tx_coding_rst_o     <= 1'b1;
        tx_buffer_rst_o     <= 1'b0;
        tx_reset_complete_o <= 1'b0; // RULE_24
        rate_run            <= 1'b0;
      end
      else
      begin
        case (tx_state)
          tsq_pkg::TX_HOLD:
          begin
            // released: run the whole analog then coding sequence
            tx_coding_rst_o <= 1'b0;
            tx_cnt          <= tsq_pkg::STAGE_LOAD;
            tx_state        <= tsq_pkg::TX_ANALOG; // RULE_22
          end
          tsq_pkg::TX_IDLE:
          begin
            if (rel[tsq_pkg::SI_TAN])
            begin
              // analog reset leaves the sequencer running
              tx_analog_rst_o     <= 1'b1; // RULE_01
              tx_cnt              <= tsq_pkg::STAGE_LOAD;
              tx_reset_complete_o <= 1'b0;
              tx_state            <= tsq_pkg::TX_ANALOG;
            end
            else if (rel[tsq_pkg::SI_TCO])
            begin
              // coding reset touches the coding layer only
              tx_reset_complete_o <= 1'b0; // RULE_01
              tx_state            <= tsq_pkg::TX_WAIT_USER;
            end
            else if (ctrl[tsq_pkg::CTRL_RATE_LSB +: 3] != tx_rate_o)
            begin
              tx_rate_o <= ctrl[tsq_pkg::CTRL_RATE_LSB +: 3];
              if (!ctrl[tsq_pkg::CTRL_STYLE_BIT])
              begin
                rate_run            <= 1'b1; // RULE_09
                tx_analog_rst_o     <= 1'b1;
                tx_cnt              <= tsq_pkg::STAGE_LOAD;
                tx_reset_complete_o <= 1'b0;
                tx_state            <= tsq_pkg::TX_ANALOG;
              end
              else
                tx_rate_change_complete_o <= 1'b1;
            end
          end
          tsq_pkg::TX_ANALOG:
          begin
            tx_analog_rst_o <= 1'b1;
            if (tx_cnt == 8'h0)
            begin
              tx_analog_rst_o <= 1'b0;
              tx_state        <= tsq_pkg::TX_WAIT_USER;
            end
            else
              tx_cnt <= tx_cnt - 8'h1;
          end
          tsq_pkg::TX_WAIT_USER:
          begin
            if (tus)
            begin
              tx_coding_rst_o <= 1'b1; // RULE_23
              tx_buffer_rst_o <= rate_run & ctrl[tsq_pkg::CTRL_CLEAR_BIT] & ctrl[tsq_pkg::CTRL_BUFEN_BIT]; // RULE_11
              tx_cnt          <= tsq_pkg::STAGE_LOAD;
              tx_state        <= tsq_pkg::TX_CODING;
            end
          end
          tsq_pkg::TX_CODING:
          begin
            if (tx_cnt == 8'h0)
            begin
              tx_coding_rst_o           <= 1'b0;
              tx_buffer_rst_o           <= 1'b0;
              tx_reset_complete_o       <= 1'b1; // RULE_24
              tx_rate_change_complete_o <= rate_run; // RULE_10
              rate_run                  <= 1'b0;
              tx_state                  <= tsq_pkg::TX_IDLE;
            end
            else
              tx_cnt <= tx_cnt - 8'h1;
          end
          default:
            tx_state <= tsq_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // rx sequencer; requests are taken only while idle, the full reset at any time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_state            <= tsq_pkg::RX_IDLE;
      rx_idx              <= 3'h0;
      rx_last             <= 3'h0;
      rx_cnt              <= 8'h0;
      rx_stage_rst_o      <= 7'h0;
      rx_reset_complete_o <= 1'b0;
    end
    else if (frx)
    begin
      rx_state            <= tsq_pkg::RX_HOLD; // RULE_13
      rx_stage_rst_o      <= 7'h7f;
      rx_reset_complete_o <= 1'b0; // RULE_25
    end
    else
    begin
      case (rx_state)
        tsq_pkg::RX_HOLD:
        begin
          rx_stage_rst_o <= stage_bit(tsq_pkg::RX_ST_ANALOG); // RULE_13
          rx_idx         <= tsq_pkg::RX_ST_ANALOG;
          rx_last        <= tsq_pkg::RX_ST_BUFFER;
          rx_cnt         <= tsq_pkg::STAGE_LOAD;
          rx_state       <= tsq_pkg::RX_STAGE;
        end
        tsq_pkg::RX_IDLE:
        begin
          // single mode: complete is low while any component reset is held
          if (!seq_mode && any_rx_req)
            rx_reset_complete_o <= 1'b0;
          if (rel[tsq_pkg::SI_RAN])
          begin
            rx_idx              <= tsq_pkg::RX_ST_ANALOG;
            rx_last             <= seq_mode ? tsq_pkg::RX_ST_BUFFER : tsq_pkg::RX_ST_ANALOG; // RULE_14 RULE_17
            rx_stage_rst_o      <= stage_bit(tsq_pkg::RX_ST_ANALOG);
            rx_cnt              <= tsq_pkg::STAGE_LOAD;
            rx_reset_complete_o <= 1'b0;
            rx_state            <= tsq_pkg::RX_STAGE;
          end
          else if (rel[tsq_pkg::SI_REQ])
          begin
            rx_idx              <= tsq_pkg::RX_ST_EQ;
            rx_last             <= seq_mode ? tsq_pkg::RX_ST_BUFFER : tsq_pkg::RX_ST_EQ; // RULE_15 RULE_18
            rx_stage_rst_o      <= stage_bit(tsq_pkg::RX_ST_EQ);
            rx_cnt              <= tsq_pkg::STAGE_LOAD;
            rx_reset_complete_o <= 1'b0;
            rx_state            <= tsq_pkg::RX_STAGE;
          end
          else if (rel[tsq_pkg::SI_RMS])
          begin
            rx_idx              <= tsq_pkg::RX_ST_SCAN;
            rx_last             <= seq_mode ? tsq_pkg::RX_ST_BUFFER : tsq_pkg::RX_ST_SCAN; // RULE_16 RULE_18
            rx_stage_rst_o      <= stage_bit(tsq_pkg::RX_ST_SCAN);
            rx_cnt              <= tsq_pkg::STAGE_LOAD;
            rx_reset_complete_o <= 1'b0;
            rx_state            <= tsq_pkg::RX_STAGE;
          end
          else if (rel[tsq_pkg::SI_RCO])
          begin
            rx_idx              <= tsq_pkg::RX_ST_CODING;
            rx_last             <= seq_mode ? tsq_pkg::RX_ST_BUFFER : tsq_pkg::RX_ST_CODING; // RULE_16 RULE_18
            rx_reset_complete_o <= 1'b0;
            rx_state            <= tsq_pkg::RX_WAIT_USER;
          end
          else if (rel[tsq_pkg::SI_REB])
          begin
            rx_idx              <= tsq_pkg::RX_ST_BUFFER;
            rx_last             <= tsq_pkg::RX_ST_BUFFER; // RULE_19
            rx_stage_rst_o      <= stage_bit(tsq_pkg::RX_ST_BUFFER);
            rx_cnt              <= tsq_pkg::STAGE_LOAD;
            rx_reset_complete_o <= 1'b0;
            rx_state            <= tsq_pkg::RX_STAGE;
          end
        end
        tsq_pkg::RX_STAGE:
        begin
          if (rx_cnt != 8'h0)
            rx_cnt <= rx_cnt - 8'h1;
          else if (rx_idx == rx_last)
          begin
            rx_stage_rst_o <= 7'h0;
            rx_state       <= tsq_pkg::RX_FINISH;
          end
          else if (rx_idx + 3'h1 == tsq_pkg::RX_ST_CODING)
          begin
            rx_stage_rst_o <= 7'h0;
            rx_idx         <= tsq_pkg::RX_ST_CODING;
            rx_state       <= tsq_pkg::RX_WAIT_USER;
          end
          else
          begin
            rx_idx         <= rx_idx + 3'h1; // RULE_14
            rx_stage_rst_o <= stage_bit(rx_idx + 3'h1);
            rx_cnt         <= tsq_pkg::STAGE_LOAD;
          end
        end
        tsq_pkg::RX_WAIT_USER:
        begin
          if (rus)
          begin
            rx_stage_rst_o <= stage_bit(tsq_pkg::RX_ST_CODING); // RULE_20
            rx_cnt         <= tsq_pkg::STAGE_LOAD;
            rx_state       <= tsq_pkg::RX_STAGE;
          end
        end
        tsq_pkg::RX_FINISH:
        begin
          if (rus)
          begin
            rx_reset_complete_o <= 1'b1; // RULE_25
            rx_state            <= tsq_pkg::RX_IDLE;
          end
        end
        default:
          rx_state <= tsq_pkg::RX_IDLE;
      endcase
    end
  end

  a_full_tx_clears: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    ftx |=> (tx_analog_rst_o && tx_coding_rst_o && !tx_reset_complete_o && tx_state == tsq_pkg::TX_HOLD))
    else $error("full tx reset did not clear all tx blocks");

  a_tx_coding_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_23
    ($rose(tx_coding_rst_o) && tx_state == tsq_pkg::TX_CODING) |-> $past(tus))
    else $error("tx coding reset started without user clocks stable");

  a_tx_done_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_24
    $rose(tx_reset_complete_o) |-> ($past(tx_state) == tsq_pkg::TX_CODING && !tx_analog_rst_o))
    else $error("tx complete rose outside the end of a sequence");

  a_rate_done_after: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    (tx_rate_change_complete_o && !$past(ctrl[tsq_pkg::CTRL_STYLE_BIT]))
      |-> (tx_reset_complete_o && !tx_coding_rst_o && $past(tx_state) == tsq_pkg::TX_CODING))
    else $error("rate change complete before its reset sequence ended");

  a_tx_buffer_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    $rose(tx_buffer_rst_o) |-> ($past(rate_run) && ctrl[tsq_pkg::CTRL_CLEAR_BIT] && tx_coding_rst_o))
    else $error("tx buffer cleared outside a rate change");

  a_rx_one_region: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_18
    (rx_state != tsq_pkg::RX_HOLD && !frx) |-> $onehot0(rx_stage_rst_o))
    else $error("more than one rx region in reset at once");

  a_rx_cascade: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
    ($fell(rx_stage_rst_o[0]) && $past(rx_state) == tsq_pkg::RX_STAGE && !frx)
      |-> (rx_last == tsq_pkg::RX_ST_ANALOG || rx_stage_rst_o == stage_bit(3'h1)))
    else $error("analog stage did not hand over to the phase stage");

  a_rx_coding_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_20
    ($rose(rx_stage_rst_o[5]) && rx_state == tsq_pkg::RX_STAGE) |-> $past(rus))
    else $error("rx coding stage started without user clocks stable");

  a_rx_done_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_25
    $rose(rx_reset_complete_o) |-> ($past(rus) && rx_stage_rst_o == 7'h0))
    else $error("rx complete rose without user clocks stable");

  a_rx_single_analog: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
    (rx_state == tsq_pkg::RX_IDLE && rel[tsq_pkg::SI_RAN] && !seq_mode && !frx)
      |=> (rx_last == tsq_pkg::RX_ST_ANALOG) [*2])
    else $error("single mode analog reset spread beyond its region");

  a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack held longer than one cycle");
endmodule

// >>> tsq_pkg.sv
// constants and types shared by the transceiver reset sequencer
//
// Notes on behaviour
// RULE_01: full tx reset clears analog, coding and sequencer; analog reset spares sequencer.
// RULE_02: controller lets the pll finish its reset before pulsing full tx reset.
// RULE_03: after a reference clock change the controller resets the pll, then full tx.
// RULE_04: after pll power-down ends the controller resets pll, waits, then full tx.
// RULE_05: after tx power-down release the controller pulses full tx reset.
// RULE_06: entering or leaving far-end loopback needs a full tx reset.
// RULE_07: controller pulses tx coding reset after the user clock source relocks.
// RULE_08: after pll settings rewrite: reset pll, wait lock, then full tx reset.
// RULE_09: rate select change with reset style zero runs the reset sequence internally.
// RULE_10: rate change complete only after new rate and its reset sequence finished.
// RULE_11: with buffer in use and clear-on-rate set, rate change resets tx buffer.
// RULE_12: in buffer bypass the controller redoes phase alignment after rate or coding reset.
// RULE_13: full rx reset in sequential mode walks through all rx analog and coding stages.
// RULE_14: sequential analog reset cascades analog, phase, frequency, equalizer, scan, coding, buffer.
// RULE_15: sequential equalizer reset cascades equalizer, scan, coding, buffer.
// RULE_16: sequential scan reset continues to coding and buffer; coding reset to buffer only.
// RULE_17: single mode analog reset touches analog stage only, not recovery or equalizer.
// RULE_18: single mode component resets act on their own region only.
// RULE_19: elastic buffer reset clears only the elastic buffer in either mode.
// RULE_20: rx coding stage waits for rx user clocks stable in both modes.
// RULE_21: controller raises rx user clocks stable only once all app clocks are stable.
// RULE_22: reset inputs are async pulses; the process starts on their release.
// RULE_23: tx coding stage waits until tx user clocks stable is sampled high.
// RULE_24: tx complete falls on full tx reset and stays low until sequence ends.
// RULE_25: sequential rx complete falls on full rx reset, rises only with user stable.
// RULE_26: controller drives reset mode select low for sequential mode.
// RULE_27: every async reset and clock-stable input passes a synchroniser first.
package tsq_pkg;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          STAGE_TIME_NS = 200;
  localparam int          STAGE_CYC     = (STAGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  STAGE_LOAD    = 8'(STAGE_CYC - 1);
  // synchronised input bit positions
  localparam int SI_FTX  = 0;
  localparam int SI_TAN  = 1;
  localparam int SI_TCO  = 2;
  localparam int SI_TUS  = 3;
  localparam int SI_FRX  = 4;
  localparam int SI_RAN  = 5;
  localparam int SI_REQ  = 6;
  localparam int SI_RMS  = 7;
  localparam int SI_RCO  = 8;
  localparam int SI_REB  = 9;
  localparam int SI_RUS  = 10;
  localparam int SI_MODE = 11;
  localparam int SI_W    = 12;
  // rx stage indices in cascade order
  localparam logic [2:0] RX_ST_ANALOG = 3'h0;
  localparam logic [2:0] RX_ST_EQ     = 3'h3;
  localparam logic [2:0] RX_ST_SCAN   = 3'h4;
  localparam logic [2:0] RX_ST_CODING = 3'h5;
  localparam logic [2:0] RX_ST_BUFFER = 3'h6;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  // control fields and reset values
  localparam int         CTRL_RATE_LSB  = 0;
  localparam int         CTRL_STYLE_BIT = 3;
  localparam int         CTRL_CLEAR_BIT = 4;
  localparam int         CTRL_BUFEN_BIT = 5;
  localparam logic [5:0] CTRL_RESET     = 6'h30;
  typedef enum logic [2:0] {TX_IDLE, TX_HOLD, TX_ANALOG, TX_WAIT_USER, TX_CODING} tsq_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_HOLD, RX_STAGE, RX_WAIT_USER, RX_FINISH} tsq_rx_e;
endpackage

// >>> tsq_sync_if.sv
// carrier for raw pin levels and their synchronised copies
`timescale 1ns/10ps
interface tsq_sync_if #(parameter int W = 12);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  modport sync (input raw, output lvl);
  modport user (output raw, input lvl);
endinterface

// >>> tsq_sync.sv
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/10ps
module tsq_sync #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin levels in, synchronised levels out
  tsq_sync_if.sync  bus
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta    <= '0;
      bus.lvl <= '0;
    end
    else
    begin
      meta    <= bus.raw; // RULE_27
      bus.lvl <= meta;
    end
  end
endmodule

// >>> tsq_partner.sv
// user-side reset controller model that pulses the asynchronous reset pins
`timescale 1ns/10ps
module tsq_partner (
  // clock
  input  wire logic       clk_i,
  // request from the bench
  input  wire logic       go_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [3:0] hold_i,
  // reset pins and status
  output logic      [8:0] pins_o,
  output logic            busy_o
);
  logic [4:0] cnt = '0;
  initial
  begin
    pins_o = '0;
    busy_o = 1'b0;
  end
  // pulse at least three cycles long so the synchroniser cannot miss it
  always @(posedge clk_i)
  begin
    if (go_i && !busy_o)
    begin
      pins_o[sel_i] <= 1'b1;
      cnt <= 5'(hold_i) + 5'h3;
      busy_o <= 1'b1;
    end
    else if (busy_o && cnt != 5'h0)
      cnt <= cnt - 5'h1;
    else if (busy_o)
    begin
      pins_o <= '0;
      busy_o <= 1'b0;
    end
  end
endmodule

// >>> tsq_top_bench.sv
// self-checking bench for the transceiver reset sequencer
`timescale 1ns/10ps
module tsq_top_bench;
  logic        clk_i, rst_i, cyc, stb, we, go, tx_us, rx_us, mode;
  logic        ack, busy, buf_seen, ana_seen, cod_seen, tx_an, tx_co, tx_buf, rt_done, tx_done, rx_done;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0]  psel, phold;
  logic [8:0]  pins;
  logic [6:0]  rx_stg, last;
  logic [6:0]  q[$];
  logic [2:0]  cur, r, rate_o;
  int          seed, n_mismatch, check_count, rt_n;
  int          st[5] = '{0, 3, 4, 5, 6};

  tsq_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .full_tx_reset_i(pins[0]), .tx_analog_layer_reset_i(pins[1]), .tx_coding_layer_reset_i(pins[2]),
    .tx_user_clocks_stable_i(tx_us), .full_rx_reset_i(pins[3]), .rx_analog_layer_reset_i(pins[4]),
    .rx_equalizer_reset_i(pins[5]), .rx_margin_scan_reset_i(pins[6]), .rx_coding_layer_reset_i(pins[7]),
    .rx_elastic_buffer_reset_i(pins[8]), .rx_user_clocks_stable_i(rx_us), .reset_mode_select_i(mode),
    .tx_analog_rst_o(tx_an), .tx_coding_rst_o(tx_co), .tx_buffer_rst_o(tx_buf), .rx_stage_rst_o(rx_stg),
    .tx_rate_o(rate_o), .tx_rate_change_complete_o(rt_done), .tx_reset_complete_o(tx_done),
    .rx_reset_complete_o(rx_done));
  tsq_partner partner_u (.clk_i(clk_i), .go_i(go), .sel_i(psel), .hold_i(phold), .pins_o(pins), .busy_o(busy));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // stage log and sightings, sampled mid-cycle where outputs are settled
  always @(negedge clk_i)
  begin
    last <= rx_stg;
    if (rx_stg != last && $countones(rx_stg) == 1)
      q.push_back(rx_stg);
    if (tx_buf)
      buf_seen <= 1'b1;
    if (tx_an)
      ana_seen <= 1'b1;
    if (tx_co)
      cod_seen <= 1'b1;
    if (rt_done)
      rt_n <= rt_n + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // request held until the edge that samples ack high; read data is taken at that same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int p);
    psel <= 4'(p);
    phold <= 4'($random(seed));
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do
      @(negedge clk_i);
    while (busy);
    @(posedge clk_i);
  endtask
  function automatic logic [6:0] exp_stage(input int s, input int i);
    return 7'h01 << (s + i);
  endfunction
  task automatic rx_wait(input int s, input logic single);
    int n;
    n = single ? 1 : 7 - s;
    while (!(q.size() >= n && rx_stg === 7'h00 && rx_done === 1'b1))
      @(negedge clk_i);
    @(posedge clk_i);
    chk(32'(q.size()), 32'(n));
    for (int i = 0; i < q.size() && i < n; i++)
      chk(32'(q[i]), 32'(exp_stage(s, i)));
    $display("rx test from stage %0d single %0d done", s, single);
  endtask
  task automatic rx_run(input int p, input int s, input logic single);
    q.delete();
    pulse(p);
    rx_wait(s, single);
  endtask
  task automatic tx_wait;
    repeat (8) @(posedge clk_i);
    while (!(tx_done === 1'b1 && tx_co === 1'b0))
      @(negedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic rate_run(input logic style);
    r = cur ^ 3'(($random(seed) & 32'h6) | 32'h1);
    ana_seen <= 1'b0;
    buf_seen <= 1'b0;
    rt_n <= 0;
    wb(1'b1, 8'h00, {26'h0, 2'b11, style, r});
    // the one-cycle complete pulse may come before the write task returns
    while (rt_n == 0)
      @(negedge clk_i);
    chk({28'h0, tx_done, rate_o}, {29'h1, r});
    @(posedge clk_i);
    chk({30'h0, buf_seen, ana_seen}, style ? 32'h0 : 32'h3);
    chk(32'(rt_n), 32'h1);
    cur = r;
    wb(1'b0, 8'h04, 32'h0);
    chk(32'(rd[12:10]), 32'(r));
    $display("rate test style %0d done", style);
  endtask

  initial
  begin
    #(40 * 20000);
    n_mismatch++;
    conclude;
  end
  initial
  begin
    {cyc, stb, we, go, tx_us, rx_us, mode, adr, wdat, psel, phold, cur} = '0;
    seed = 96;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    mode <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h30);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    tx_us <= 1'b1;
    pulse(0);
    tx_wait;
    chk(32'(tx_done), 32'h1);
    $display("tx full reset test done");
    tx_us <= 1'b0;
    pulse(0);
    repeat (40) @(posedge clk_i);
    chk({29'h0, tx_done, tx_co, tx_an}, 32'h0);
    tx_us <= 1'b1;
    tx_wait;
    chk(32'(tx_done), 32'h1);
    $display("tx user clock gate test done");
    for (int p = 1; p < 3; p++)
    begin
      ana_seen <= 1'b0;
      cod_seen <= 1'b0;
      pulse(p);
      tx_wait;
      chk({30'h0, ana_seen, cod_seen}, p == 1 ? 32'h3 : 32'h1);
      $display("tx component test %0d done", p);
    end
    for (int i = 0; i < 4; i++)
      rate_run(i[0]);
    rx_us <= 1'b1;
    for (int i = 0; i < 5; i++)
      rx_run(i + 4, st[i], 1'b0);
    rx_us <= 1'b0;
    q.delete();
    pulse(3);
    repeat (60) @(posedge clk_i);
    chk({24'h0, rx_done, 7'(q.size())}, 32'h5);
    rx_us <= 1'b1;
    rx_wait(0, 1'b0);
    mode <= 1'b1;
    repeat (5) @(posedge clk_i);
    for (int i = 0; i < 5; i++)
      rx_run(i + 4, st[i], 1'b1);
    conclude;
  end
endmodule
